/* File: design/rnt_consts.svh */
// Constants for register number translation and special register checks.
// Assumes inclusion by bare name from the design files.
`ifndef RNT_CONSTS_SVH
`define RNT_CONSTS_SVH

// ****************************************
// Register number space
// ****************************************
`define RNT_NUM_W        8
`define RNT_GLOBAL_COUNT 64
`define RNT_LOCAL_COUNT  128
`define RNT_IND_NUM      8'h00
`define RNT_SP_NUM       8'h01

// ****************************************
// Field positions
// ****************************************
`define RNT_SP_MSB       8
`define RNT_SP_LSB       2
`define RNT_PTR_MSB      9
`define RNT_PTR_LSB      2
`define RNT_BANK_MSB     7
`define RNT_BANK_LSB     4

// ****************************************
// Special register map and ranges
// ****************************************
`define RNT_SPR_RESULT_PTR 8'h80
`define RNT_SPR_FIRST_PTR  8'h81
`define RNT_SPR_SECOND_PTR 8'h82
`define RNT_SPR_OPEN_LO    8'h80
`define RNT_SPR_OPEN_HI    8'h9F

// ****************************************
// Reset values and timing
// ****************************************
`define RNT_PTR_RESET    8'h00
`define RNT_SP_RESET     7'h00
`define RNT_UPD_DELAY    2

`endif

/* File: design/rnt_pkg.sv */
// Types shared by the register number translation design.
// Assumes nothing beyond a SystemVerilog compiler.
package rnt_pkg;

   // ****************************************
   // Special register access classes
   // ****************************************
   typedef enum logic [1:0] {
      RNT_SPR_SUPER,
      RNT_SPR_OPEN,
      RNT_SPR_VIRT
   } rnt_spr_class_t;

endpackage : rnt_pkg

/* File: design/rnt_spr_check.sv */
// Special register number classifier and protection trap decision.
// Assumes a registered caller; this module is purely combinational.
`timescale 1ns/100ps
`include "rnt_consts.svh"

module rnt_spr_check (
   input  wire logic [7:0]          spr_num,
   input  wire logic                spr_user,
   output rnt_pkg::rnt_spr_class_t  spr_class,
   output logic                     spr_trap
);

   // ****************************************
   // Range decode
   // ****************************************
   always_comb begin
      if (spr_num < `RNT_SPR_OPEN_LO) begin
         spr_class = rnt_pkg::RNT_SPR_SUPER;
      end else if (spr_num <= `RNT_SPR_OPEN_HI) begin
         spr_class = rnt_pkg::RNT_SPR_OPEN;
      end else begin
         spr_class = rnt_pkg::RNT_SPR_VIRT;
      end
   end

   // ****************************************
   // Trap decision
   // ****************************************
   always_comb begin
      case (spr_class)
         rnt_pkg::RNT_SPR_SUPER: spr_trap = spr_user;   // [RL10]
         rnt_pkg::RNT_SPR_OPEN:  spr_trap = 1'h0;       // [RL11]
         rnt_pkg::RNT_SPR_VIRT:  spr_trap = 1'h1;       // [RL12]
         default:                spr_trap = 1'h1;
      endcase
   end

endmodule : rnt_spr_check

/* File: design/rnt_top.sv */
// Register number translation, indirect pointers and special register access.
// Assumes decoder and pipeline share core_clk and all inputs are synchronous.
//
// Overview of operation
// [RL1] Register number MSB selects global or local
// [RL2] Global numbers pass through unchanged
// [RL3] Local: add stack pointer bits 8-2, force MSB
// [RL4] Unbacked globals still get bank protection check
// [RL5] Field value zero uses its indirect pointer
// [RL6] Stack shadow updates only from arithmetic/logical writes
// [RL7] Stack pointer change takes effect after delay
// [RL8] Reserved bits read zero, writes ignored
// [RL9] Special registers selected only by direct number
// [RL10] Specials 0-127 supervisor only, else trap
// [RL11] Specials 128-159 open to both modes
// [RL12] Specials 160-255 always trap
// [RL13] Unimplemented open special writes change nothing
// [RL14] Three independent absolute 8-bit indirect pointers
// [RL15] Pointer loading instruction classes
// [RL16] Move-to-special loads pointer from bits 9-2
// [RL17] Other setters load all three translated numbers
// [RL18] Non-move pointer loads get bank protection check
// [RL19] New values apply after parameterised delay
`timescale 1ns/100ps
`include "rnt_consts.svh"

module rnt_top #(
   parameter int UPD_DELAY = `RNT_UPD_DELAY
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        dec_valid,
   input  wire logic [7:0]  dec_field_a,
   input  wire logic [7:0]  dec_field_b,
   input  wire logic [7:0]  dec_field_c,
   input  wire logic        dec_user,
   input  wire logic [15:0] bank_protect_reg,
   input  wire logic        sp_wr_valid,
   input  wire logic        sp_wr_alu,
   input  wire logic [31:0] sp_wr_data,
   input  wire logic        ptr_set_valid,
   input  wire logic        spr_valid,
   input  wire logic        spr_write,
   input  wire logic [7:0]  spr_num,
   input  wire logic [31:0] spr_wdata,
   input  wire logic        spr_user,
   output logic [7:0]       abs_a,
   output logic [7:0]       abs_b,
   output logic [7:0]       abs_c,
   output logic             abs_valid,
   output logic             bank_viol,
   output logic             ptr_bank_viol,
   output logic [31:0]      spr_rdata,
   output logic             spr_trap,
   output logic             spr_done
);

   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta;
   logic rst_q;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta <= 1'h0;
         rst_q    <= 1'h0;
      end else begin
         rst_meta <= 1'h1;
         rst_q    <= rst_meta;
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] xlate(input logic [7:0] rn, input logic [6:0] sp,
                                        input logic [7:0] ip);
      if (rn == `RNT_IND_NUM) begin
         xlate = ip;                                     // [RL5] [RL14]
      end else if (rn[7]) begin
         xlate = {1'h1, 7'(rn[6:0] + sp)};               // [RL1] [RL3]
      end else begin
         xlate = rn;                                     // [RL1] [RL2]
      end
   endfunction : xlate

   // Bank granularity is sixteen registers per protect bit
   function automatic logic bank_hit(input logic [7:0] n, input logic user,
                                     input logic [15:0] prot);
      bank_hit = user & prot[n[`RNT_BANK_MSB:`RNT_BANK_LSB]];
   endfunction : bank_hit

   // ****************************************
   // Special register classification
   // ****************************************
   rnt_pkg::rnt_spr_class_t spr_class;
   logic                    spr_trap_c;

   // Only the instruction's own number field reaches this check [RL9]
   rnt_spr_check u_check (
      .spr_num   (spr_num),
      .spr_user  (spr_user),
      .spr_class (spr_class),
      .spr_trap  (spr_trap_c)
   );

   // ****************************************
   // State
   // ****************************************
   logic [6:0] eff_sp;
   logic [7:0] eff_ptr [3];
   logic [7:0] arch_ptr [3];
   logic       sp_pipe_v [UPD_DELAY];
   logic [6:0] sp_pipe_d [UPD_DELAY];
   logic [2:0] ptr_pipe_m [UPD_DELAY];
   logic [7:0] ptr_pipe_d [UPD_DELAY][3];

   logic [6:0] next_eff_sp;
   logic [7:0] next_eff_ptr [3];
   logic [7:0] next_arch_ptr [3];
   logic       next_sp_pipe_v [UPD_DELAY];
   logic [6:0] next_sp_pipe_d [UPD_DELAY];
   logic [2:0] next_ptr_pipe_m [UPD_DELAY];
   logic [7:0] next_ptr_pipe_d [UPD_DELAY][3];

   logic [7:0]  next_abs_a;
   logic [7:0]  next_abs_b;
   logic [7:0]  next_abs_c;
   logic        next_abs_valid;
   logic        next_bank_viol;
   logic        next_ptr_bank_viol;
   logic [31:0] next_spr_rdata;
   logic        next_spr_trap;
   logic        next_spr_done;

   // Pointer index 0 = result, 1 = first source, 2 = second source
   logic [7:0] set_val [3];
   logic [2:0] set_mask;
   logic       spr_wr_ok;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_abs_a = xlate(dec_field_a, eff_sp, eff_ptr[1]);
      next_abs_b = xlate(dec_field_b, eff_sp, eff_ptr[2]);
      next_abs_c = xlate(dec_field_c, eff_sp, eff_ptr[0]);
      next_abs_valid = dec_valid;
      next_bank_viol = dec_valid & (bank_hit(next_abs_a, dec_user, bank_protect_reg) |
                                    bank_hit(next_abs_b, dec_user, bank_protect_reg) |
                                    bank_hit(next_abs_c, dec_user, bank_protect_reg)); // [RL4]

      // Pointer sources: setter instructions win over a same-cycle move
      spr_wr_ok = spr_valid & spr_write & ~spr_trap_c;
      set_mask  = 3'h0;
      for (int i = 0; i < 3; i++) begin
         set_val[i] = spr_wdata[`RNT_PTR_MSB:`RNT_PTR_LSB];          // [RL16]
      end
      if (ptr_set_valid) begin
         set_mask   = 3'h7;                                          // [RL15] [RL17]
         set_val[0] = next_abs_c;
         set_val[1] = next_abs_a;
         set_val[2] = next_abs_b;
      end else if (spr_wr_ok) begin
         // Other open numbers have no storage, so the write is dropped [RL13]
         set_mask[0] = (spr_num == `RNT_SPR_RESULT_PTR);             // [RL15]
         set_mask[1] = (spr_num == `RNT_SPR_FIRST_PTR);
         set_mask[2] = (spr_num == `RNT_SPR_SECOND_PTR);
      end
      next_ptr_bank_viol = ptr_set_valid & (bank_hit(next_abs_a, dec_user, bank_protect_reg) |
                                            bank_hit(next_abs_b, dec_user, bank_protect_reg) |
                                            bank_hit(next_abs_c, dec_user, bank_protect_reg)); // [RL18]

      for (int i = 0; i < 3; i++) begin
         next_arch_ptr[i] = set_mask[i] ? set_val[i] : arch_ptr[i];  // [RL14]
      end

      // Delay lines: effect reaches decoding only after UPD_DELAY stages
      next_sp_pipe_v[0]  = sp_wr_valid & sp_wr_alu;                  // [RL6]
      next_sp_pipe_d[0]  = sp_wr_data[`RNT_SP_MSB:`RNT_SP_LSB];
      next_ptr_pipe_m[0] = set_mask;
      for (int i = 0; i < 3; i++) begin
         next_ptr_pipe_d[0][i] = set_val[i];
      end
      for (int s = 1; s < UPD_DELAY; s++) begin
         next_sp_pipe_v[s]  = sp_pipe_v[s-1];                        // [RL7] [RL19]
         next_sp_pipe_d[s]  = sp_pipe_d[s-1];
         next_ptr_pipe_m[s] = ptr_pipe_m[s-1];
         for (int i = 0; i < 3; i++) begin
            next_ptr_pipe_d[s][i] = ptr_pipe_d[s-1][i];
         end
      end
      next_eff_sp = sp_pipe_v[UPD_DELAY-1] ? sp_pipe_d[UPD_DELAY-1] : eff_sp; // [RL7]
      for (int i = 0; i < 3; i++) begin
         next_eff_ptr[i] = ptr_pipe_m[UPD_DELAY-1][i] ? ptr_pipe_d[UPD_DELAY-1][i]
                                                      : eff_ptr[i];  // [RL16] [RL19]
      end

      // Reads: pointer fields in bits 9-2, all else zero [RL8]
      next_spr_rdata = 32'h0000_0000;
      if (spr_valid & ~spr_write & ~spr_trap_c) begin
         case (spr_num)
            `RNT_SPR_RESULT_PTR: next_spr_rdata[`RNT_PTR_MSB:`RNT_PTR_LSB] = arch_ptr[0];
            `RNT_SPR_FIRST_PTR:  next_spr_rdata[`RNT_PTR_MSB:`RNT_PTR_LSB] = arch_ptr[1];
            `RNT_SPR_SECOND_PTR: next_spr_rdata[`RNT_PTR_MSB:`RNT_PTR_LSB] = arch_ptr[2];
            default:             next_spr_rdata = 32'h0000_0000;
         endcase
      end
      next_spr_trap = spr_valid & spr_trap_c;                        // [RL10] [RL12]
      next_spr_done = spr_valid;
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_q) begin
      if (!rst_q) begin
         eff_sp        <= `RNT_SP_RESET;
         abs_a         <= 8'h00;
         abs_b         <= 8'h00;
         abs_c         <= 8'h00;
         abs_valid     <= 1'h0;
         bank_viol     <= 1'h0;
         ptr_bank_viol <= 1'h0;
         spr_rdata     <= 32'h0000_0000;
         spr_trap      <= 1'h0;
         spr_done      <= 1'h0;
         for (int i = 0; i < 3; i++) begin
            eff_ptr[i]  <= `RNT_PTR_RESET;
            arch_ptr[i] <= `RNT_PTR_RESET;
         end
         for (int s = 0; s < UPD_DELAY; s++) begin
            sp_pipe_v[s]  <= 1'h0;
            sp_pipe_d[s]  <= `RNT_SP_RESET;
            ptr_pipe_m[s] <= 3'h0;
            for (int i = 0; i < 3; i++) begin
               ptr_pipe_d[s][i] <= `RNT_PTR_RESET;
            end
         end
      end else begin
         eff_sp        <= next_eff_sp;
         abs_a         <= next_abs_a;
         abs_b         <= next_abs_b;
         abs_c         <= next_abs_c;
         abs_valid     <= next_abs_valid;
         bank_viol     <= next_bank_viol;
         ptr_bank_viol <= next_ptr_bank_viol;
         spr_rdata     <= next_spr_rdata;
         spr_trap      <= next_spr_trap;
         spr_done      <= next_spr_done;
         eff_ptr       <= next_eff_ptr;
         arch_ptr      <= next_arch_ptr;
         sp_pipe_v     <= next_sp_pipe_v;
         sp_pipe_d     <= next_sp_pipe_d;
         ptr_pipe_m    <= next_ptr_pipe_m;
         ptr_pipe_d    <= next_ptr_pipe_d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_q);

   AST_GLOBAL_PASS: assert property ( // [RL2]
      dec_valid && !dec_field_a[7] && dec_field_a != 8'h00 |=> abs_a == $past(dec_field_a))
      else $error("global number altered");

   AST_LOCAL_SUM: assert property ( // [RL3]
      dec_valid && dec_field_b[7] |=> abs_b == {1'h1, 7'($past(dec_field_b[6:0]) + $past(eff_sp))})
      else $error("local number sum wrong");

   AST_INDIRECT: assert property ( // [RL5]
      dec_valid && dec_field_c == 8'h00 |=> abs_c == $past(eff_ptr[0]))
      else $error("indirect pointer not used");

   AST_SP_NOT_IMMEDIATE: assert property ( // [RL7]
      sp_wr_valid && !sp_pipe_v[UPD_DELAY-1] |=> eff_sp == $past(eff_sp))
      else $error("stack shadow changed without delay");

   AST_SP_ALU_ONLY: assert property ( // [RL6]
      !sp_wr_valid || !sp_wr_alu |=> !sp_pipe_v[0])
      else $error("shadow update from wrong class");

   AST_SUPER_TRAP: assert property ( // [RL10]
      spr_valid && spr_user && spr_num < 8'h80 |=> spr_trap && spr_done)
      else $error("user access to supervisor register not trapped");

   AST_OPEN_NO_TRAP: assert property ( // [RL11]
      spr_valid && spr_num >= 8'h80 && spr_num <= 8'h9F |=> !spr_trap)
      else $error("open register trapped");

   AST_VIRT_TRAP: assert property ( // [RL12]
      spr_valid && spr_num >= 8'hA0 |=> spr_trap)
      else $error("virtual register not trapped");

   AST_RSV_ZERO: assert property ( // [RL8]
      spr_done |-> spr_rdata[31:10] == 22'h0 && spr_rdata[1:0] == 2'h0)
      else $error("reserved bits not zero");

   AST_MOVE_LOAD: assert property ( // [RL16]
      spr_valid && spr_write && spr_num == 8'h81 && !ptr_set_valid
      |=> arch_ptr[1] == $past(spr_wdata[9:2]))
      else $error("pointer move load wrong");

   AST_SET_LOAD: assert property ( // [RL17]
      ptr_set_valid && !dec_field_b[7] && dec_field_b != 8'h00 |=> arch_ptr[2] == $past(dec_field_b))
      else $error("pointer set load wrong");

endmodule : rnt_top

/* File: test/rnt_pipe_model.sv */
// Decoder and pipeline stand-in that issues requests to the block.
// Assumes one caller, one request at a time, on core_clk.
`timescale 1ns/100ps

module rnt_pipe_model (
   input  wire logic core_clk,
   output logic      dec_valid,
   output logic [7:0]  dec_field_a,
   output logic [7:0]  dec_field_b,
   output logic [7:0]  dec_field_c,
   output logic        dec_user,
   output logic [15:0] bank_protect_reg,
   output logic        sp_wr_valid,
   output logic        sp_wr_alu,
   output logic [31:0] sp_wr_data,
   output logic        ptr_set_valid,
   output logic        spr_valid,
   output logic        spr_write,
   output logic [7:0]  spr_num,
   output logic [31:0] spr_wdata,
   output logic        spr_user
);
   initial begin
      {dec_valid, dec_field_a, dec_field_b, dec_field_c, dec_user, bank_protect_reg} = '0;
      {sp_wr_valid, sp_wr_alu, sp_wr_data, ptr_set_valid} = '0;
      {spr_valid, spr_write, spr_num, spr_wdata, spr_user} = '0;
   end

   // Flip idle data so a stale value is never mistaken for a fresh one
   task automatic fin();
      @(posedge core_clk);
      {dec_valid, ptr_set_valid, spr_valid, sp_wr_valid} <= 4'h0;
      {dec_field_a, dec_field_b, dec_field_c} <= ~{dec_field_a, dec_field_b, dec_field_c};
      {sp_wr_data, spr_wdata, spr_num} <= ~{sp_wr_data, spr_wdata, spr_num};
      @(negedge core_clk);
   endtask : fin

   task automatic dec(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                      input logic u, input logic [15:0] p, input logic set);
      @(posedge core_clk);
      {dec_field_a, dec_field_b, dec_field_c, dec_user, bank_protect_reg} <= {a, b, c, u, p};
      dec_valid     <= !set;
      ptr_set_valid <= set;
      fin();
   endtask : dec

   task automatic spw(input logic alu, input logic [31:0] d);
      @(posedge core_clk);
      {sp_wr_valid, sp_wr_alu, sp_wr_data} <= {1'h1, alu, d};
      fin();
   endtask : spw

   task automatic spr(input logic wr, input logic [7:0] n, input logic [31:0] d, input logic u);
      @(posedge core_clk);
      {spr_valid, spr_write, spr_num, spr_wdata, spr_user} <= {1'h1, wr, n, d, u};
      fin();
   endtask : spr
endmodule : rnt_pipe_model

/* File: test/tb.sv */
// Self-checking bench for register number translation.
// Assumes the pipeline stand-in drives every request input.
`timescale 1ns/100ps

module tb;
   localparam int D = 2;
   logic core_clk = 1'h0;
   logic rst_b    = 1'h0;
   logic dec_valid, dec_user, sp_wr_valid, sp_wr_alu, ptr_set_valid, spr_valid, spr_write, spr_user;
   logic [7:0] dec_field_a, dec_field_b, dec_field_c, spr_num, abs_a, abs_b, abs_c;
   logic [15:0] bank_protect_reg;
   logic [31:0] sp_wr_data, spr_wdata, spr_rdata;
   logic abs_valid, bank_viol, ptr_bank_viol, spr_trap, spr_done;
   int bad_count = 0;
   int compares  = 0;
   int cycles    = 0;
   typedef struct {logic [7:0] a, b, c; logic u; logic [15:0] p; logic [7:0] ea, eb, ec; logic ev;} rnt_row_t;
   // Shadow holds 0x7C during these rows
   rnt_row_t rows [6] = '{
      '{8'h01, 8'h3F, 8'h40, 1'h1, 16'h0000, 8'h01, 8'h3F, 8'h40, 1'h0},
      '{8'h85, 8'hFF, 8'h80, 1'h1, 16'h0000, 8'h81, 8'hFB, 8'hFC, 1'h0},
      '{8'h85, 8'h02, 8'h10, 1'h1, 16'h0100, 8'h81, 8'h02, 8'h10, 1'h1},
      '{8'h85, 8'h02, 8'h10, 1'h0, 16'h0100, 8'h81, 8'h02, 8'h10, 1'h0},
      '{8'h02, 8'h20, 8'h3F, 1'h1, 16'h0001, 8'h02, 8'h20, 8'h3F, 1'h1},
      '{8'h41, 8'h7F, 8'hC4, 1'h1, 16'h0001, 8'h41, 8'h7F, 8'hC0, 1'h0}};
   logic [7:0]  pn [3] = '{8'h80, 8'h81, 8'h82};
   logic [31:0] pw [3] = '{32'hFFFF_FE50, 32'h8000_0207, 32'hFFFF_FFFF};
   logic [31:0] pe [3] = '{32'h0000_0200, 32'h0000_021C, 32'h0000_000C};
   logic [7:0]  sn [6] = '{8'h00, 8'h7F, 8'h80, 8'h9F, 8'hA0, 8'hFF};

   always #10 core_clk = ~core_clk;

   rnt_pipe_model u_pipe (.core_clk, .dec_valid, .dec_field_a, .dec_field_b, .dec_field_c, .dec_user,
      .bank_protect_reg, .sp_wr_valid, .sp_wr_alu, .sp_wr_data, .ptr_set_valid, .spr_valid, .spr_write,
      .spr_num, .spr_wdata, .spr_user);

   rnt_top #(.UPD_DELAY(D)) DUT (.core_clk, .rst_b, .dec_valid, .dec_field_a, .dec_field_b,
      .dec_field_c, .dec_user, .bank_protect_reg, .sp_wr_valid, .sp_wr_alu, .sp_wr_data, .ptr_set_valid,
      .spr_valid, .spr_write, .spr_num, .spr_wdata, .spr_user, .abs_a, .abs_b, .abs_c, .abs_valid,
      .bank_viol, .ptr_bank_viol, .spr_rdata, .spr_trap, .spr_done);

   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic dchk(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic u,
                       input logic [15:0] p, input logic [7:0] ea, input logic [7:0] eb,
                       input logic [7:0] ec, input logic ev);
      u_pipe.dec(a, b, c, u, p, 1'h0);
      chk(abs_valid, 1'h1);
      chk({abs_a, abs_b, abs_c}, {ea, eb, ec});
      chk(bank_viol, ev);
      chk(ptr_bank_viol, 1'h0);
   endtask : dchk

   task automatic summarize();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   // Generous ceiling; the full run needs about 125 cycles
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         summarize();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge core_clk);
      chk({abs_valid, spr_done, spr_trap, abs_a}, 32'h0);
      repeat (8) @(posedge core_clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge core_clk);
      u_pipe.spw(1'h1, 32'h0000_01F0);
      repeat (D + 2) @(posedge core_clk);
      foreach (rows[i]) begin
         dchk(rows[i].a, rows[i].b, rows[i].c, rows[i].u, rows[i].p, rows[i].ea, rows[i].eb, rows[i].ec,
              rows[i].ev);
         $display("row %0d done", i);
      end
      u_pipe.spw(1'h0, 32'h0000_0000);
      repeat (D + 2) @(posedge core_clk);
      dchk(8'h85, 8'h85, 8'h85, 1'h0, 16'h0000, 8'h81, 8'h81, 8'h81, 1'h0);
      u_pipe.spw(1'h1, 32'h0000_0008);
      dchk(8'h85, 8'h85, 8'h85, 1'h0, 16'h0000, 8'h81, 8'h81, 8'h81, 1'h0);
      repeat (D + 2) @(posedge core_clk);
      dchk(8'h85, 8'h85, 8'h85, 1'h0, 16'h0000, 8'h87, 8'h87, 8'h87, 1'h0);
      $display("stack shadow test done");
      foreach (pn[i]) begin
         u_pipe.spr(1'h1, pn[i], pw[i], 1'h1);
         chk({spr_done, spr_trap}, 2'h2);
         u_pipe.spr(1'h0, pn[i], 32'h0000_0000, 1'h1);
         chk(spr_rdata, pw[i] & 32'h0000_03FC);
      end
      repeat (D + 2) @(posedge core_clk);
      // Pointer 0x81 must not pick up the stack offset of 2
      dchk(8'h00, 8'h00, 8'h00, 1'h1, 16'h8000, 8'h81, 8'hFF, 8'h94, 1'h1);
      $display("pointer move test done");
      u_pipe.dec(8'h85, 8'h03, 8'hFE, 1'h1, 16'h0001, 1'h1);
      chk(ptr_bank_viol, 1'h1);
      foreach (pn[i]) begin
         u_pipe.spr(1'h0, pn[i], 32'h0000_0000, 1'h0);
         chk(spr_rdata, pe[i]);
      end
      repeat (D + 2) @(posedge core_clk);
      dchk(8'h00, 8'h00, 8'h00, 1'h0, 16'h0000, 8'h87, 8'h03, 8'h80, 1'h0);
      $display("pointer set test done");
      for (int u = 0; u < 2; u++) begin
         foreach (sn[i]) begin
            u_pipe.spr(1'h0, sn[i], 32'h0000_0000, u[0]);
            chk(spr_done, 1'h1);
            chk(spr_trap, (sn[i] >= 8'hA0) || (u[0] && sn[i] < 8'h80));
         end
      end
      u_pipe.spr(1'h1, 8'h83, 32'hFFFF_FFFF, 1'h0);
      u_pipe.spr(1'h0, 8'h83, 32'h0000_0000, 1'h0);
      chk(spr_rdata, 32'h0000_0000);
      $display("special access test done");
      @(posedge core_clk);
      rst_b <= 1'h0;
      repeat (2) @(posedge core_clk);
      chk({abs_valid, spr_done, spr_rdata[7:0], abs_c}, 32'h0);
      rst_b <= 1'h1;
      repeat (3) @(posedge core_clk);
      u_pipe.spr(1'h0, 8'h80, 32'h0000_0000, 1'h0);
      chk(spr_rdata, 32'h0000_0000);
      dchk(8'h85, 8'h00, 8'h00, 1'h0, 16'h0000, 8'h85, 8'h00, 8'h00, 1'h0);
      $display("reset test done");
      summarize();
   end
endmodule : tb
